// file: shared/ssmt_defines.vh
/*
 Constants for the clock-synchronous serial master transmitter.
 Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef SSMT_DEFINES_VH
`define SSMT_DEFINES_VH

`define SSMT_CKSRC_INTERNAL 2'h0
`define SSMT_PRESCALE_DIV1 2'h0
`define SSMT_BRR_DEFAULT 8'h77
`define SSMT_PCLK_HZ 48000000
`define SSMT_SYS_HZ 40000000
`define SSMT_DATA_BITS 4'h8
`define SSMT_BITCNT_LAST 3'h7
`define SSMT_SYNC_RST 2'h0

`endif

// file: verilog/ssmt_sync2.v
/*
 Two-flop synchroniser for single-bit inputs arriving from another domain.
 Assumes one system clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssmt_defines.vh"

module ssmt_sync2 #(
	parameter WIDTH = 1
) (
	input wire i_sys_clk,
	input wire i_srst,
	input wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule // ssmt_sync2

`default_nettype wire

// file: verilog/ssmt_master_tx.v
/*
 Clock-synchronous master transmitter of one serial channel: data holding
 register, shift register, baud generator, shift clock output and status
 flags. Control bits arrive as plain ports from logic on the same clock;
 the transmit-empty acknowledge comes from an interrupt controller on the
 same clock. The port output latches belong to the port block and are
 treated as foreign, so they pass two flip-flops first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssmt_defines.vh"

module ssmt_master_tx #(
	parameter DATA_W = 8
) (
	input wire i_sys_clk,
	input wire i_srst,
	input wire i_clock_source_sel_lo,
	input wire i_clock_source_sel_hi,
	input wire i_sync_mode_select,
	input wire i_bit_order_sel,
	input wire i_data_invert_sel,
	input wire i_smart_card_mode_sel,
	input wire i_simple_i2c_sel,
	input wire i_clock_phase_sel,
	input wire i_clock_polarity_sel,
	input wire i_baud_prescale_sel_lo,
	input wire i_baud_prescale_sel_hi,
	input wire [7:0] i_bit_rate_divider,
	input wire i_tx_enable_bit,
	input wire i_tx_empty_irq_en,
	input wire i_tx_done_irq_en,
	input wire i_rx_full_irq_en,
	input wire [DATA_W-1:0] i_tx_data,
	input wire i_tx_data_wr,
	input wire i_tx_empty_req_clr,
	input wire i_tx_empty_irq_ack,
	input wire i_port_output_latch_tx,
	input wire i_port_output_latch_clk,
	output reg o_tx_data_pin,
	output reg o_channel_clock_pin,
	output reg o_channel_clock_pin_oe_n,
	output reg o_tx_empty_flag,
	output reg o_tx_done_flag,
	output reg o_rx_full_flag,
	output reg o_overrun_flag,
	output reg o_tx_empty_request_flag,
	output reg o_tx_empty_irq,
	output reg o_tx_done_irq,
	output reg o_rx_error_irq
);
	localparam ST_IDLE = 1'b0;
	localparam ST_SHIFT = 1'b1;

	wire [1:0] cksrc = {i_clock_source_sel_hi, i_clock_source_sel_lo};
	wire [1:0] presc = {i_baud_prescale_sel_hi, i_baud_prescale_sel_lo};
	// Default operation only: special modes stop the shifter
	wire mode_ok = i_sync_mode_select & ~i_smart_card_mode_sel & ~i_simple_i2c_sel
		& ~i_clock_phase_sel & ~i_clock_polarity_sel;
	wire int_clk = (cksrc == `SSMT_CKSRC_INTERNAL);
	wire run = i_tx_enable_bit & mode_ok & int_clk;

	// Synced inverted: the synchroniser resets to 0, lines must idle high
	wire [1:0] latch_n_sync;
	ssmt_sync2 #(
		.WIDTH(2)
	) u_latch_sync (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_async({~i_port_output_latch_tx, ~i_port_output_latch_clk}),
		.o_sync(latch_n_sync)
	);

	// Half-bit tick: each shift clock half lasts 4^n*(N+1) system clocks
	reg [13:0] baud_cnt_r;
	reg [13:0] baud_top;
	reg half_tick;
	always @* begin
		case (presc)
		2'h0: baud_top = {6'h0, i_bit_rate_divider} + 14'h1;
		2'h1: baud_top = {4'h0, i_bit_rate_divider, 2'h0} + 14'h4;
		2'h2: baud_top = {2'h0, i_bit_rate_divider, 4'h0} + 14'h10;
		default: baud_top = {i_bit_rate_divider, 6'h0} + 14'h40;
		endcase
		half_tick = (baud_cnt_r == baud_top - 14'h1);
	end

	reg state_r;
	reg [DATA_W-1:0] hold_r;
	reg hold_full_r;
	reg [DATA_W-1:0] shift_r;
	reg [2:0] bit_cnt_r;
	reg phase_r;
	wire [DATA_W-1:0] load_val = i_data_invert_sel ? ~hold_r : hold_r;
	wire out_bit = i_bit_order_sel ? shift_r[DATA_W-1] : shift_r[0];

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			baud_cnt_r <= 14'h0;
			state_r <= ST_IDLE;
			hold_r <= {DATA_W{1'b0}};
			hold_full_r <= 1'b0;
			shift_r <= {DATA_W{1'b0}};
			bit_cnt_r <= 3'h0;
			phase_r <= 1'b0;
			o_tx_data_pin <= 1'b1;
			o_channel_clock_pin <= 1'b1;
			o_channel_clock_pin_oe_n <= 1'b1;
			o_tx_empty_flag <= 1'b1;
			o_tx_done_flag <= 1'b1;
			o_rx_full_flag <= 1'b0;
			o_overrun_flag <= 1'b0;
			o_tx_empty_request_flag <= 1'b0;
			o_tx_empty_irq <= 1'b0;
			o_tx_done_irq <= 1'b0;
			o_rx_error_irq <= 1'b0;
		end else begin
			// Pin is ours only with internal clock and transmitter enabled
			o_channel_clock_pin_oe_n <= ~run;
			if (!run) begin
				// Idle lines follow the preset port latches
				baud_cnt_r <= 14'h0;
				state_r <= ST_IDLE;
				phase_r <= 1'b0;
				o_tx_data_pin <= ~latch_n_sync[1];
				o_channel_clock_pin <= ~latch_n_sync[0];
				if (!i_tx_enable_bit) begin
					hold_full_r <= 1'b0;
					o_tx_empty_flag <= 1'b1;
					o_tx_done_flag <= 1'b1;
				end
			end else begin
				baud_cnt_r <= half_tick ? 14'h0 : baud_cnt_r + 14'h1;
				case (state_r)
				ST_IDLE: begin
					o_channel_clock_pin <= 1'b1;
					if (hold_full_r) begin
						shift_r <= load_val;
						hold_full_r <= 1'b0;
						o_tx_empty_flag <= 1'b1;
						o_tx_done_flag <= 1'b0;
						bit_cnt_r <= 3'h0;
						phase_r <= 1'b0;
						baud_cnt_r <= 14'h0;
						state_r <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (half_tick) begin
						phase_r <= ~phase_r;
						if (!phase_r) begin
							// Falling edge presents the bit
							o_channel_clock_pin <= 1'b0;
							o_tx_data_pin <= out_bit;
						end else begin
							// Rising edge: slave samples, then advance
							o_channel_clock_pin <= 1'b1;
							shift_r <= i_bit_order_sel ? {shift_r[DATA_W-2:0], 1'b0}
								: {1'b0, shift_r[DATA_W-1:1]};
							bit_cnt_r <= bit_cnt_r + 3'h1;
							if (bit_cnt_r == `SSMT_BITCNT_LAST) begin
								if (hold_full_r) begin
									// Back-to-back byte, no idle gap
									shift_r <= load_val;
									hold_full_r <= 1'b0;
									o_tx_empty_flag <= 1'b1;
								end else begin
									state_r <= ST_IDLE;
									o_tx_done_flag <= 1'b1;
								end
							end
						end
					end
				end
				default: state_r <= ST_IDLE;
				endcase
			end
			// Host write fills the holding register; it wins over unload
			if (i_tx_data_wr && i_tx_enable_bit) begin
				hold_r <= i_tx_data;
				hold_full_r <= 1'b1;
				o_tx_empty_flag <= 1'b0;
				o_tx_done_flag <= 1'b0;
			end
			// Request set when the shifter takes the holding register; set wins over clear or ack
			if (run && o_tx_empty_flag == 1'b0 && state_r == ST_SHIFT && hold_full_r
				&& half_tick && phase_r && bit_cnt_r == `SSMT_BITCNT_LAST)
				o_tx_empty_request_flag <= 1'b1;
			else if (run && state_r == ST_IDLE && hold_full_r)
				o_tx_empty_request_flag <= 1'b1;
			else if (i_tx_empty_irq_ack || i_tx_empty_req_clr)
				o_tx_empty_request_flag <= 1'b0;
			o_tx_empty_irq <= i_tx_empty_irq_en & o_tx_empty_request_flag
				& ~i_tx_empty_irq_ack;
			o_tx_done_irq <= i_tx_done_irq_en & o_tx_done_flag;
			// No receiver: full and overrun stay clear, no other error source
			o_rx_full_flag <= 1'b0;
			o_overrun_flag <= 1'b0;
			o_rx_error_irq <= i_rx_full_irq_en & o_overrun_flag;
		end
	end
endmodule // ssmt_master_tx

`default_nettype wire

// file: test/ssmt_tx_monitor.sv
/* Port checker for the serial master transmitter.
 Assumes one clock, synchronous reset, bound to the transmitter module. */
`timescale 1ns/1ps
`default_nettype none
module ssmt_tx_monitor(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_clock_source_sel_lo,
	input wire logic i_clock_source_sel_hi,
	input wire logic i_sync_mode_select,
	input wire logic i_baud_prescale_sel_lo,
	input wire logic i_baud_prescale_sel_hi,
	input wire logic [7:0] i_bit_rate_divider,
	input wire logic i_tx_enable_bit,
	input wire logic i_tx_data_wr,
	input wire logic i_tx_empty_irq_ack,
	input wire logic o_channel_clock_pin,
	input wire logic o_channel_clock_pin_oe_n,
	input wire logic o_tx_empty_flag,
	input wire logic o_tx_done_flag,
	input wire logic o_rx_full_flag,
	input wire logic o_tx_empty_request_flag
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	sequence s_idle_wr;
		i_tx_data_wr && i_tx_enable_bit && o_tx_done_flag && o_tx_empty_flag;
	endsequence
	sequence s_load;
		!o_tx_empty_flag ##1 (o_tx_empty_flag && o_tx_empty_request_flag && !o_tx_done_flag);
	endsequence
	a_load_walk: assert property (s_idle_wr |=> s_load) else $error("load walk");
	a_rx_quiet: assert property (!o_rx_full_flag) else $error("rx flag");
	a_ack_clears: assert property (i_tx_empty_irq_ack && o_tx_empty_flag && !i_tx_data_wr
		|=> !o_tx_empty_request_flag) else $error("ack");
	a_wr_taken: assert property (i_tx_data_wr && i_tx_enable_bit |=> !o_tx_empty_flag)
		else $error("wr");
	a_off_idle: assert property (!i_tx_enable_bit |=> o_tx_empty_flag && o_tx_done_flag)
		else $error("off");
	a_clk_master: assert property (!o_channel_clock_pin_oe_n |-> !$past(i_clock_source_sel_lo)
		&& !$past(i_clock_source_sel_hi) && $past(i_sync_mode_select))
		else $error("clk out");
	a_clk_half: assert property ($fell(o_channel_clock_pin) && i_bit_rate_divider == 8'h01
		&& !i_baud_prescale_sel_lo && !i_baud_prescale_sel_hi
		|-> !o_channel_clock_pin[*2] ##1 o_channel_clock_pin) else $error("half");
	a_done_empty: assert property ($rose(o_tx_done_flag) |-> o_tx_empty_flag)
		else $error("done");
endmodule // ssmt_tx_monitor
bind ssmt_master_tx ssmt_tx_monitor mon(.*);
`default_nettype wire

// file: test/ssmt_slave_rx.sv
/* Slave receiver model: takes a bit at each rising shift clock.
 Assumes the master drives the clock only while its enable is low. */
`timescale 1ns/1ps
`default_nettype none
module ssmt_slave_rx(
	input wire logic i_sck,
	input wire logic i_sd,
	input wire logic i_oe_n,
	output logic [7:0] o_byte,
	output int o_cnt
);
	logic [2:0] nbit = 3'h0;
	initial o_cnt = 0;
	// First bit lands in bit 0, so msb-first traffic arrives reversed
	always @(posedge i_sck) if (!i_oe_n) begin
		o_byte <= {i_sd, o_byte[7:1]};
		nbit <= nbit + 3'h1;
		if (nbit == 3'h7) o_cnt <= o_cnt + 1;
	end
endmodule // ssmt_slave_rx
`default_nettype wire

// file: test/tb_top.sv
/* Testbench for the serial master transmitter.
 Assumes the slave model and the bound checker are compiled before. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_sys_clk=0, i_srst=1, i_clock_source_sel_lo=0, i_clock_source_sel_hi=0;
	logic i_sync_mode_select=1, i_bit_order_sel=0, i_data_invert_sel=0;
	logic i_smart_card_mode_sel=0, i_simple_i2c_sel=0, i_clock_phase_sel=0;
	logic i_clock_polarity_sel=0, i_baud_prescale_sel_lo=0, i_baud_prescale_sel_hi=0;
	logic i_tx_enable_bit=0, i_tx_empty_irq_en=0, i_tx_done_irq_en=0, i_rx_full_irq_en=0;
	logic i_tx_data_wr=0, i_tx_empty_req_clr=0, i_tx_empty_irq_ack=0;
	logic i_port_output_latch_tx=1, i_port_output_latch_clk=1;
	logic [7:0] i_bit_rate_divider=8'h01, i_tx_data=8'h00, rx_byte, b, e;
	logic o_tx_data_pin, o_channel_clock_pin, o_channel_clock_pin_oe_n, o_tx_empty_flag;
	logic o_tx_done_flag, o_rx_full_flag, o_overrun_flag, o_tx_empty_request_flag;
	logic o_tx_empty_irq, o_tx_done_irq, o_rx_error_irq;
	logic [7:0] exp_q[$];
	int rx_cnt, t, n_mismatch=0, compares=0;
	int seen=0;
	ssmt_master_tx dut(.*);
	ssmt_slave_rx peer(.i_sck(o_channel_clock_pin), .i_sd(o_tx_data_pin),
		.i_oe_n(o_channel_clock_pin_oe_n), .o_byte(rx_byte), .o_cnt(rx_cnt));
	initial forever #12.5 i_sys_clk = ~i_sys_clk;
	task automatic chk(string nm, logic [7:0] x, logic [7:0] s);
		compares++;
		if (s !== x) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic send(logic [7:0] v, logic [7:0] x);
		t = 0;
		do @(negedge i_sys_clk); while (o_tx_empty_flag !== 1'b1 && ++t < 400);
		if (o_tx_empty_flag !== 1'b1) n_mismatch++;
		// Random choice between interrupt acceptance and software clear
		@(posedge i_sys_clk) i_tx_empty_irq_ack <= v[0];
		i_tx_empty_req_clr <= !v[0];
		@(posedge i_sys_clk) {i_tx_empty_irq_ack, i_tx_empty_req_clr} <= 2'h0;
		i_tx_data <= v;
		i_tx_data_wr <= 1;
		exp_q.push_back(x);
		@(posedge i_sys_clk) i_tx_data_wr <= 0;
	endtask
	// Shift clock moves only on rising system edges, so the byte is settled here
	always @(negedge i_sys_clk) if (rx_cnt != seen) begin
		seen = rx_cnt;
		chk("rx byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, rx_byte);
	end
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(9));
		repeat (2) @(posedge i_sys_clk);
		i_srst <= 0;
		@(negedge i_sys_clk) chk("reset flags", 8'h03, {o_tx_empty_request_flag,
			o_tx_empty_flag, o_tx_done_flag});
		for (int m = 0; m < 3; m++) begin
			@(posedge i_sys_clk) i_data_invert_sel <= (m == 1);
			i_bit_order_sel <= (m == 2);
			repeat (8) @(posedge i_sys_clk);
			{i_tx_empty_irq_en, i_tx_enable_bit, i_tx_done_irq_en} <= 3'h7;
			repeat (m ? 4 : 32) begin
				b = $urandom;
				e = b;
				if (m == 2) e = {<<{b}};
				send(b, e ^ {8{m == 1}});
			end
			t = 0;
			do @(negedge i_sys_clk); while (!(o_tx_done_flag === 1'b1 && exp_q.size() == 0)
				&& ++t < 2000);
			chk("done flag", 8'h01, o_tx_done_flag);
			@(negedge i_sys_clk) chk("done irq", 8'h01, o_tx_done_irq);
			chk("empty irq", 8'h01, o_tx_empty_irq);
			@(posedge i_sys_clk) {i_tx_empty_irq_en, i_tx_enable_bit, i_tx_done_irq_en} <= 3'h0;
			$display("mode %0d test done", m);
		end
		// Write with transmitter off must not reach the line
		@(posedge i_sys_clk) i_tx_data_wr <= 1;
		@(posedge i_sys_clk) i_tx_data_wr <= 0;
		repeat (80) @(negedge i_sys_clk);
		chk("byte count", 8'h28, rx_cnt[7:0]);
		chk("rx flags", 8'h00, {o_rx_full_flag, o_overrun_flag, o_rx_error_irq});
		$display("disabled write test done");
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
